// File: hdl/scc_synth_regs.sv
// synth clock configuration registers with axi4-lite access
//
// What this block does
// - three clock output enables, reset 1, drive pin when set, tri-state when clear
// - any write to soft reset restores all synth registers 72h-98h; data ignored
// - override 0 and strap low: oscillator enable reads 0, writes ignored
// - override 0 and strap high: oscillator enable defaults 1, writable
// - override 1: oscillator enable defaults 1 regardless of strap, writable
// - override 0: synth b enable held 0, writes ignored
// - override 1: synth b enable defaults 1, writable, 1 runs it
// - override 0: synth c enable held 0, writes ignored
// - override 1: synth c enable defaults 1, writable, 1 runs it
// - reference select 0 picks internal oscillator, 1 the external master clock
// - synth c source 0 follows reference select, 1 the frequency-locked loop
// - fractional enable per synth, default 1: 0 integer mode, 1 fractional
// - synth b integer multiplier, 5 bits 4:0, reset seven
// - synth c integer multiplier, 5 bits 4:0, reset seven
// - synth b fractional multiplier 24 bits from three byte registers
// - synth c fractional high and middle bytes reset 48h and 22h
// - synth c fractional low byte in next register, reset 97h
// - sequencer enable defaults 1; 0 disables, 1 enables
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "scc_cfg.svh"
module scc_synth_regs
    import scc_pkg::*;
#(
    parameter logic [7:0] B_FRAC_HI_RST = 8'h00
)(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [9:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [9:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // strap
    input  wire logic        strap_pin,
    // clock output pin enables
    output logic             clk_out_b_drive_en,
    output logic             clk_out_c_drive_en,
    output logic             clk_out_e_drive_en,
    // synthesizer controls
    output logic             internal_osc_enable,
    output logic             synth_b_enable,
    output logic             synth_c_enable,
    output logic             synth_ref_select,
    output logic             synth_c_from_freq_loop,
    output logic             synth_sequencer_enable,
    output logic             synth_b_fractional_en,
    output logic             synth_c_fractional_en,
    output logic [4:0]       synth_b_int_mult,
    output logic [4:0]       synth_c_int_mult,
    output logic [23:0]      synth_b_frac_mult,
    output logic [23:0]      synth_c_frac_mult,
    output logic [28:0]      synth_b_ratio,
    output logic [28:0]      synth_c_ratio
);
    scc_regs_s q;
    scc_regs_s d;

    logic        wr_en;
    logic [9:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        rd_en;
    logic [9:0]  rd_addr;
    logic [31:0] rd_data;
    logic        osc_wr_ok;
    logic [7:0]  widx;
    logic [15:0] cur;
    logic [15:0] nv;

    function automatic logic [7:0] idx_of(input logic [9:0] a);
        return a[9:2];
    endfunction

    function automatic logic idx_ok(input logic [9:0] a);
        logic [7:0] i;
        i = idx_of(a);
        if (a[1:0] != 2'h0) begin
            return 1'b0;
        end
        unique case (i)
            `SCC_IDX_OVR, `SCC_IDX_OE, `SCC_IDX_SRST, `SCC_IDX_ENA, `SCC_IDX_SRC,
            `SCC_IDX_B_INT, `SCC_IDX_B_FH, `SCC_IDX_B_FM, `SCC_IDX_B_FL,
            `SCC_IDX_C_INT, `SCC_IDX_C_FH, `SCC_IDX_C_FM, `SCC_IDX_C_FL,
            `SCC_IDX_SEQ: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [28:0] ratio(input logic fr, input logic [4:0] n,
                                          input logic [23:0] k);
        return {n, fr ? k : 24'h0};
    endfunction

    // defaults of the synth range; the override bit lives outside it and is kept
    function automatic scc_regs_s dflt(input logic ovr);
        scc_regs_s r;
        r           = '0;
        r.ovr       = ovr;
        r.oe_b      = 1'b1;
        r.oe_c      = 1'b1;
        r.oe_e      = 1'b1;
        r.osc       = 1'b1;
        r.en_b      = 1'b1;
        r.en_c      = 1'b1;
        r.ref_sel   = 1'b0;
        r.c_loop    = 1'b0;
        r.seq       = 1'b1;
        r.b_frac_en = 1'b1;
        r.c_frac_en = 1'b1;
        r.b_n       = `SCC_RST_INT;
        r.c_n       = `SCC_RST_INT;
        r.b_k       = {B_FRAC_HI_RST, `SCC_RST_B_FM, `SCC_RST_B_FL};
        r.c_k       = {`SCC_RST_C_FH, `SCC_RST_C_FM, `SCC_RST_C_FL};
        r.b_ratio   = ratio(1'b1, r.b_n, r.b_k);
        r.c_ratio   = ratio(1'b1, r.c_n, r.c_k);
        return r;
    endfunction

    localparam scc_regs_s RST_STATE = dflt(1'b0);

    // register view; read-only bits show their forced level
    function automatic logic [15:0] view(input logic [7:0] i, input scc_regs_s s,
                                         input logic osc_on);
        logic [15:0] v;
        v = 16'h0;
        unique case (i)
            `SCC_IDX_OVR: v[`SCC_BIT_OVR] = s.ovr;
            `SCC_IDX_OE: begin
                v                = `SCC_RSV_OE;
                v[`SCC_BIT_OE_B] = s.oe_b;
                v[`SCC_BIT_OE_C] = s.oe_c;
                v[`SCC_BIT_OE_E] = s.oe_e;
            end
            `SCC_IDX_ENA: begin
                v                = `SCC_RSV_ENA;
                v[`SCC_BIT_OSC]  = s.osc & osc_on;
                v[`SCC_BIT_EN_B] = s.en_b & s.ovr;
                v[`SCC_BIT_EN_C] = s.en_c & s.ovr;
            end
            `SCC_IDX_SRC: begin
                v                 = `SCC_RSV_SRC;
                v[`SCC_BIT_REF]   = s.ref_sel;
                v[`SCC_BIT_C_LOOP] = s.c_loop;
            end
            `SCC_IDX_B_INT: v = {9'h0, s.b_frac_en, 1'b0, s.b_n};
            `SCC_IDX_B_FH:  v = {8'h0, s.b_k[23:16]};
            `SCC_IDX_B_FM:  v = {8'h0, s.b_k[15:8]};
            `SCC_IDX_B_FL:  v = {8'h0, s.b_k[7:0]};
            `SCC_IDX_C_INT: v = {9'h0, s.c_frac_en, 1'b0, s.c_n};
            `SCC_IDX_C_FH:  v = {8'h0, s.c_k[23:16]};
            `SCC_IDX_C_FM:  v = {8'h0, s.c_k[15:8]};
            `SCC_IDX_C_FL:  v = {8'h0, s.c_k[7:0]};
            `SCC_IDX_SEQ: begin
                v               = `SCC_RSV_SEQ;
                v[`SCC_BIT_SEQ] = s.seq;
            end
            default: v = 16'h0;
        endcase
        return v;
    endfunction

    scc_axil_port u_port (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_err  (!idx_ok(wr_addr)),
        .rd_en   (rd_en),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_err  (!idx_ok(rd_addr))
    );

    // strap is sampled live, so the oscillator lock follows the pin
    assign osc_wr_ok = q.ovr | strap_pin;
    assign rd_data   = {16'h0, view(idx_of(rd_addr), q, osc_wr_ok)};
    assign widx      = idx_of(wr_addr);
    assign cur       = view(widx, q, osc_wr_ok);
    assign nv        = (cur & ~{{8{wr_strb[1]}}, {8{wr_strb[0]}}})
                     | (wr_data[15:0] & {{8{wr_strb[1]}}, {8{wr_strb[0]}}});

    always_comb begin
        d = q;
        if (wr_en && idx_ok(wr_addr)) begin
            unique case (widx)
                `SCC_IDX_OVR: d.ovr = nv[`SCC_BIT_OVR];
                `SCC_IDX_SRST: d = dflt(q.ovr);
                `SCC_IDX_OE: begin
                    d.oe_b = nv[`SCC_BIT_OE_B];
                    d.oe_c = nv[`SCC_BIT_OE_C];
                    d.oe_e = nv[`SCC_BIT_OE_E];
                end
                `SCC_IDX_ENA: begin
                    if (osc_wr_ok) begin
                        d.osc = nv[`SCC_BIT_OSC];
                    end
                    if (q.ovr) begin
                        d.en_b = nv[`SCC_BIT_EN_B];
                        d.en_c = nv[`SCC_BIT_EN_C];
                    end
                end
                `SCC_IDX_SRC: begin
                    d.ref_sel = nv[`SCC_BIT_REF];
                    d.c_loop  = nv[`SCC_BIT_C_LOOP];
                end
                `SCC_IDX_B_INT: begin
                    d.b_frac_en = nv[`SCC_BIT_FRAC];
                    d.b_n       = nv[4:0];
                end
                `SCC_IDX_B_FH: d.b_k[23:16] = nv[7:0];
                `SCC_IDX_B_FM: d.b_k[15:8]  = nv[7:0];
                `SCC_IDX_B_FL: d.b_k[7:0]   = nv[7:0];
                `SCC_IDX_C_INT: begin
                    d.c_frac_en = nv[`SCC_BIT_FRAC];
                    d.c_n       = nv[4:0];
                end
                `SCC_IDX_C_FH: d.c_k[23:16] = nv[7:0];
                `SCC_IDX_C_FM: d.c_k[15:8]  = nv[7:0];
                `SCC_IDX_C_FL: d.c_k[7:0]   = nv[7:0];
                `SCC_IDX_SEQ: d.seq = nv[`SCC_BIT_SEQ];
                default: d = q;
            endcase
        end
        // ratio trails its fields by one cycle, kept in flops so the outputs stay clean
        d.b_ratio = ratio(q.b_frac_en, q.b_n, q.b_k);
        d.c_ratio = ratio(q.c_frac_en, q.c_n, q.c_k);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= RST_STATE;
        end else begin
            q <= d;
        end
    end

    assign clk_out_b_drive_en     = q.oe_b;
    assign clk_out_c_drive_en     = q.oe_c;
    assign clk_out_e_drive_en     = q.oe_e;
    assign internal_osc_enable    = q.osc & osc_wr_ok;
    assign synth_b_enable         = q.en_b & q.ovr;
    assign synth_c_enable         = q.en_c & q.ovr;
    assign synth_ref_select       = q.ref_sel;
    assign synth_c_from_freq_loop = q.c_loop;
    // no interlock with the reference select; software keeps them consistent
    assign synth_sequencer_enable = q.seq;
    assign synth_b_fractional_en  = q.b_frac_en;
    assign synth_c_fractional_en  = q.c_frac_en;
    assign synth_b_int_mult       = q.b_n;
    assign synth_c_int_mult       = q.c_n;
    assign synth_b_frac_mult      = q.b_k;
    assign synth_c_frac_mult      = q.c_k;
    assign synth_b_ratio          = q.b_ratio;
    assign synth_c_ratio          = q.c_ratio;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic wr_ena_lo;
    assign wr_ena_lo = wr_en && wr_addr == {`SCC_IDX_ENA, 2'h0} && wr_strb[0];

    oe_write_a: assert property (
        wr_en && wr_addr == {`SCC_IDX_OE, 2'h0} && wr_strb[0]
        |=> clk_out_b_drive_en == $past(wr_data[3]) && clk_out_e_drive_en == $past(wr_data[0]))
        else $error("clock output enable did not follow write");
    soft_reset_a: assert property (
        wr_en && wr_addr == {`SCC_IDX_SRST, 2'h0}
        |=> synth_b_int_mult == 5'h07 && synth_c_frac_mult == 24'h482297 && synth_sequencer_enable)
        else $error("soft reset did not restore defaults");
    osc_locked_a: assert property (
        !q.ovr && !strap_pin |-> !internal_osc_enable
            && (rd_data[7] == 1'b0 || idx_of(rd_addr) != `SCC_IDX_ENA))
        else $error("oscillator enable not forced off");
    osc_strap_wr_a: assert property (
        wr_ena_lo && !q.ovr && strap_pin ##1 strap_pin
        |-> internal_osc_enable == $past(wr_data[7]))
        else $error("oscillator enable not writable with strap high");
    osc_ovr_wr_a: assert property (
        wr_ena_lo && q.ovr ##1 q.ovr |-> internal_osc_enable == $past(wr_data[7]))
        else $error("oscillator enable not writable under override");
    synth_held_a: assert property (
        !q.ovr |-> !synth_b_enable && !synth_c_enable
            && (rd_data[5:4] == 2'h0 || idx_of(rd_addr) != `SCC_IDX_ENA))
        else $error("synth enable not held off");
    synth_c_ignore_a: assert property (
        wr_ena_lo && !q.ovr |=> q.en_c == $past(q.en_c) && q.en_b == $past(q.en_b))
        else $error("synth enable took a locked write");
    synth_wr_a: assert property (
        wr_ena_lo && q.ovr ##1 q.ovr
        |-> synth_b_enable == $past(wr_data[5]) && synth_c_enable == $past(wr_data[4]))
        else $error("synth enable not writable under override");
    int_reset_a: assert property (
        $past(!aresetn) |-> synth_b_int_mult == 5'h07 && synth_c_int_mult == 5'h07
            && synth_b_fractional_en && synth_c_fractional_en)
        else $error("integer multiplier reset value wrong");
    ratio_a: assert property (
        1'b1 |=> synth_c_ratio[28:24] == $past(synth_c_int_mult)
            && synth_c_ratio[23:0] == ($past(synth_c_fractional_en)
                ? $past(synth_c_frac_mult) : 24'h0))
        else $error("synth c ratio mismatch");
endmodule
`default_nettype wire

// File: shared/scc_cfg.svh
// register indices, field positions and reset values of the synth clock block
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

`define SCC_IDX_OVR    8'h70
`define SCC_IDX_OE     8'h7e
`define SCC_IDX_SRST   8'h7f
`define SCC_IDX_ENA    8'h81
`define SCC_IDX_SRC    8'h83
`define SCC_IDX_B_INT  8'h88
`define SCC_IDX_B_FH   8'h89
`define SCC_IDX_B_FM   8'h8a
`define SCC_IDX_B_FL   8'h8b
`define SCC_IDX_C_INT  8'h8c
`define SCC_IDX_C_FH   8'h8d
`define SCC_IDX_C_FM   8'h8e
`define SCC_IDX_C_FL   8'h8f
`define SCC_IDX_SEQ    8'h96
`define SCC_IDX_RST_LO 8'h72
`define SCC_IDX_RST_HI 8'h98

`define SCC_BIT_OVR    0
`define SCC_BIT_OE_B   3
`define SCC_BIT_OE_C   2
`define SCC_BIT_OE_E   0
`define SCC_BIT_OSC    7
`define SCC_BIT_EN_B   5
`define SCC_BIT_EN_C   4
`define SCC_BIT_REF    1
`define SCC_BIT_C_LOOP 0
`define SCC_BIT_FRAC   6
`define SCC_BIT_SEQ    1

`define SCC_RSV_OE     16'h0012
`define SCC_RSV_ENA    16'h0001
`define SCC_RSV_SRC    16'h0010
`define SCC_RSV_SEQ    16'h0001

`define SCC_RST_INT    5'h07
`define SCC_RST_B_FM   8'h71
`define SCC_RST_B_FL   8'hc7
`define SCC_RST_C_FH   8'h48
`define SCC_RST_C_FM   8'h22
`define SCC_RST_C_FL   8'h97

`endif

// File: shared/scc_pkg.sv
// state types of the synth clock configuration block
package scc_pkg;

    typedef struct packed {
        logic        ovr;
        logic        oe_b;
        logic        oe_c;
        logic        oe_e;
        logic        osc;
        logic        en_b;
        logic        en_c;
        logic        ref_sel;
        logic        c_loop;
        logic        seq;
        logic        b_frac_en;
        logic [4:0]  b_n;
        logic [23:0] b_k;
        logic        c_frac_en;
        logic [4:0]  c_n;
        logic [23:0] c_k;
        logic [28:0] b_ratio;
        logic [28:0] c_ratio;
    } scc_regs_s;

    typedef struct packed {
        logic        aw_held;
        logic        w_held;
        logic [9:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } scc_axi_s;

endpackage

// File: hdl/scc_axil_port.sv
// axi4-lite slave handshake front end for the synth clock registers
`timescale 1ns/1ps
`default_nettype none
module scc_axil_port
    import scc_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [9:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [9:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // register file side
    output logic             wr_en,
    output logic [9:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_err,
    output logic             rd_en,
    output logic [9:0]       rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_err
);
    scc_axi_s q;
    scc_axi_s d;

    assign awready = !q.aw_held && !q.bvalid;
    assign wready  = !q.w_held && !q.bvalid;
    assign arready = !q.rvalid;
    // write fires only once both halves are held, so address and data may come in any order
    assign wr_en   = q.aw_held && q.w_held && !q.bvalid;
    assign wr_addr = q.awaddr;
    assign wr_data = q.wdata;
    assign wr_strb = q.wstrb;
    assign rd_en   = arvalid && arready;
    assign rd_addr = araddr;
    assign bvalid  = q.bvalid;
    assign bresp   = q.bresp;
    assign rvalid  = q.rvalid;
    assign rdata   = q.rdata;
    assign rresp   = q.rresp;

    always_comb begin
        d = q;
        if (awvalid && awready) begin
            d.aw_held = 1'b1;
            d.awaddr  = awaddr;
        end
        if (wvalid && wready) begin
            d.w_held = 1'b1;
            d.wdata  = wdata;
            d.wstrb  = wstrb;
        end
        if (wr_en) begin
            d.aw_held = 1'b0;
            d.w_held  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = wr_err ? 2'h2 : 2'h0;
        end else if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        if (rd_en) begin
            d.rvalid = 1'b1;
            d.rdata  = rd_err ? 32'h0 : rd_data;
            d.rresp  = rd_err ? 2'h2 : 2'h0;
        end else if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the synth clock configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "scc_cfg.svh"
module testbench;
    logic        aclk, aresetn, strap_pin;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [9:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        clk_out_b_drive_en, clk_out_c_drive_en, clk_out_e_drive_en;
    logic        internal_osc_enable, synth_b_enable, synth_c_enable;
    logic        synth_ref_select, synth_c_from_freq_loop, synth_sequencer_enable;
    logic        synth_b_fractional_en, synth_c_fractional_en;
    logic [4:0]  synth_b_int_mult, synth_c_int_mult;
    logic [23:0] synth_b_frac_mult, synth_c_frac_mult;
    logic [28:0] synth_b_ratio, synth_c_ratio;
    int          fails, checks_done;

    // non-zero fraction high byte so its reset path is visible
    scc_synth_regs #(.B_FRAC_HI_RST(8'h3c)) i_dut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .strap_pin, .clk_out_b_drive_en, .clk_out_c_drive_en,
        .clk_out_e_drive_en, .internal_osc_enable, .synth_b_enable, .synth_c_enable,
        .synth_ref_select, .synth_c_from_freq_loop, .synth_sequencer_enable,
        .synth_b_fractional_en, .synth_c_fractional_en, .synth_b_int_mult,
        .synth_c_int_mult, .synth_b_frac_mult, .synth_c_frac_mult, .synth_b_ratio,
        .synth_c_ratio
    );

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // handshakes are judged at the falling edge, where nothing moves
    task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [1:0] er);
        int n;
        logic ta, tw, b;
        logic [1:0] resp;
        n = 0;
        b = 1'b0;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {16'h0000, d};
        wstrb <= 4'h3;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b) begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            b = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
            if (n > 50) begin
                fails++;
                summarize();
            end
        end
        bready <= 1'b0;
        chk(resp, er);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
        int n;
        logic ta, r;
        logic [31:0] d;
        logic [1:0] resp;
        n = 0;
        r = 1'b0;
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r) begin
            @(negedge aclk);
            ta = arvalid & arready;
            r = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            n++;
            if (n > 50) begin
                fails++;
                summarize();
            end
        end
        rready <= 1'b0;
        chk(d, ed);
        chk(resp, er);
    endtask

    task automatic settle;
        repeat (2) @(negedge aclk);
    endtask

    initial begin
        {aresetn, strap_pin, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        chk({clk_out_b_drive_en, clk_out_c_drive_en, clk_out_e_drive_en}, 3'b111);
        chk({internal_osc_enable, synth_b_enable, synth_c_enable}, 3'b000);
        chk({synth_ref_select, synth_c_from_freq_loop}, 2'b00);
        chk({synth_b_fractional_en, synth_c_fractional_en}, 2'b11);
        chk({synth_b_int_mult, synth_c_int_mult}, {5'h07, 5'h07});
        chk(synth_b_frac_mult, 24'h3c71c7);
        chk(synth_c_frac_mult, 24'h482297);
        chk(synth_sequencer_enable, 1'b1);
        chk(synth_b_ratio, {5'h07, 24'h3c71c7});
        chk(synth_c_ratio, {5'h07, 24'h482297});
        rd(`SCC_IDX_OE, 32'h0000001f, 2'b00);
        rd(`SCC_IDX_ENA, 32'h00000001, 2'b00);
        rd(`SCC_IDX_SRC, 32'h00000010, 2'b00);
        rd(`SCC_IDX_C_INT, 32'h00000047, 2'b00);
        rd(`SCC_IDX_C_FL, 32'h00000097, 2'b00);
        rd(`SCC_IDX_SEQ, 32'h00000003, 2'b00);
        rd(`SCC_IDX_SRST, 32'h00000000, 2'b00);
        rd(8'h00, 32'h00000000, 2'b10);
        // locked enables while override is clear
        wr(`SCC_IDX_ENA, 16'h0031, 2'b00);
        settle();
        chk({internal_osc_enable, synth_b_enable, synth_c_enable}, 3'b000);
        @(posedge aclk);
        strap_pin <= 1'b1;
        settle();
        chk(internal_osc_enable, 1'b1);
        rd(`SCC_IDX_ENA, 32'h00000081, 2'b00);
        wr(`SCC_IDX_ENA, 16'h0001, 2'b00);
        settle();
        chk(internal_osc_enable, 1'b0);
        wr(`SCC_IDX_OVR, 16'h0001, 2'b00);
        settle();
        chk({synth_b_enable, synth_c_enable}, 2'b11);
        wr(`SCC_IDX_ENA, 16'h0091, 2'b00);
        settle();
        chk({internal_osc_enable, synth_b_enable, synth_c_enable}, 3'b101);
        // clock output pins and sources; sequencer off before the external reference
        wr(`SCC_IDX_OE, 16'h001a, 2'b00);
        settle();
        chk({clk_out_b_drive_en, clk_out_c_drive_en, clk_out_e_drive_en}, 3'b100);
        wr(`SCC_IDX_SEQ, 16'h0001, 2'b00);
        wr(`SCC_IDX_SRC, 16'h0013, 2'b00);
        settle();
        chk({synth_ref_select, synth_c_from_freq_loop}, 2'b11);
        chk(synth_sequencer_enable, 1'b0);
        // multipliers, integer mode on synth b
        wr(`SCC_IDX_B_INT, 16'h001f, 2'b00);
        wr(`SCC_IDX_B_FH, 16'h00ab, 2'b00);
        wr(`SCC_IDX_B_FM, 16'h00cd, 2'b00);
        wr(`SCC_IDX_B_FL, 16'h00ef, 2'b00);
        wr(`SCC_IDX_C_INT, 16'h0043, 2'b00);
        wr(`SCC_IDX_C_FH, 16'h0011, 2'b00);
        wr(`SCC_IDX_C_FM, 16'h00ff, 2'b00);
        wr(`SCC_IDX_C_FL, 16'h0055, 2'b00);
        wr(8'h90, 16'hffff, 2'b10);
        settle();
        chk({synth_b_fractional_en, synth_b_int_mult}, {1'b0, 5'h1f});
        chk(synth_b_frac_mult, 24'habcdef);
        chk(synth_b_ratio, {5'h1f, 24'h000000});
        chk(synth_c_int_mult, 5'h03);
        chk(synth_c_frac_mult, 24'h11ff55);
        chk(synth_c_ratio, {5'h03, 24'h11ff55});
        rd(`SCC_IDX_B_FM, 32'h000000cd, 2'b00);
        // soft reset with strap low and override kept
        @(posedge aclk);
        strap_pin <= 1'b0;
        wr(`SCC_IDX_SRST, 16'h5a5a, 2'b00);
        settle();
        chk({clk_out_b_drive_en, clk_out_c_drive_en, clk_out_e_drive_en}, 3'b111);
        chk({internal_osc_enable, synth_b_enable, synth_c_enable}, 3'b111);
        chk({synth_ref_select, synth_c_from_freq_loop, synth_sequencer_enable}, 3'b001);
        chk({synth_b_fractional_en, synth_b_int_mult}, {1'b1, 5'h07});
        chk(synth_c_frac_mult, 24'h482297);
        chk(synth_b_ratio, {5'h07, 24'h3c71c7});
        chk(synth_c_ratio, {5'h07, 24'h482297});
        wr(`SCC_IDX_OVR, 16'h0000, 2'b00);
        settle();
        chk({internal_osc_enable, synth_b_enable, synth_c_enable}, 3'b000);
        // hardware reset in mid-run also clears the override
        wr(`SCC_IDX_OVR, 16'h0001, 2'b00);
        wr(`SCC_IDX_B_INT, 16'h0003, 2'b00);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        chk({internal_osc_enable, synth_b_enable, synth_c_enable}, 3'b000);
        chk({synth_b_fractional_en, synth_b_int_mult}, {1'b1, 5'h07});
        summarize();
    end
endmodule
`default_nettype wire
